// ==== bench/pfm_mux_bench.sv ====
// Self-checking bench of the port function mux
`default_nettype none
module pfm_mux_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pfm_pkg::*;
  typedef struct packed {
    logic [3:0]  a;
    logic [7:0]  d;
    logic [1:0]  p;
    logic [23:0] e;
    logic [23:0] m;
  } pfm_row_type;
  // One register write, the port looked at, expected pad drive and care mask
  localparam pfm_row_type ROWS [21] = '{
    '{4'h2, 8'hFF, 2'h0, 24'h00FFFF, 24'hFFFFFF}, '{4'h1, 8'hA5, 2'h0, 24'hA5FFFF, 24'hFFFFFF},
    '{4'h3, 8'hFF, 2'h0, 24'h26FF00, 24'hFFFF00}, '{4'h2, 8'h00, 2'h0, 24'h000000, 24'h00FF00},
    '{4'hC, 8'hFC, 2'h0, 24'h000000, 24'hFCFFFC}, '{4'hC, 8'h00, 2'h0, 24'h000000, 24'h00FF00},
    '{4'h3, 8'h00, 2'h0, 24'hA500FF, 24'hFFFFFF}, '{4'h2, 8'hFF, 2'h0, 24'hA5FFFF, 24'hFFFFFF},
    '{4'h1, 8'hFF, 2'h0, 24'hFFFFFF, 24'hFFFFFF}, '{4'hE, 8'h01, 2'h0, 24'hEFEFEF, 24'hFFFFFF},
    '{4'h6, 8'hFF, 2'h1, 24'h00FFFF, 24'hFFFFFF}, '{4'h5, 8'h3C, 2'h1, 24'h3CFFFF, 24'hFFFFFF},
    '{4'hD, 8'h04, 2'h1, 24'h3DFFFC, 24'hFFFFFF}, '{4'hD, 8'h07, 2'h1, 24'h95FF00, 24'hFFFFFF},
    '{4'hD, 8'h01, 2'h1, 24'hBCFF3F, 24'hFFFFFF}, '{4'hD, 8'h02, 2'h1, 24'h14FFC3, 24'hFFFFFF},
    '{4'hD, 8'h00, 2'h1, 24'h3CFFFF, 24'hFFFFFF}, '{4'h7, 8'hFF, 2'h1, 24'h00FF00, 24'hFFFF00},
    '{4'h6, 8'h0F, 2'h1, 24'h000F00, 24'h0FFF00}, '{4'hA, 8'hFF, 2'h2, 24'h00FFFF, 24'hFFFFFF},
    '{4'hB, 8'hFF, 2'h2, 24'hD7FF00, 24'hFFFFFF}};
  logic clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0, flip = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, p1_in = 8'h00, p2_in = 8'h00, p5_in = 8'h00;
  logic [13:0] lcd_seg;
  logic [3:1] lcd_com;
  logic [2:0] sd_neg_pin;
  logic dac_out_en;
  logic [23:0] pad;
  pfm_pad_type p1_pad, p2_pad, p5_pad;
  pfm_timer_out_type tmr_out;
  pfm_timer_in_type tmr_in;
  int err_total = 0, n_tests = 0, cyc = 0;
  pfm_mux dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .p1_in(p1_in), .p2_in(p2_in), .p5_in(p5_in), .p1_pad(p1_pad),
    .p2_pad(p2_pad), .p5_pad(p5_pad), .tmr_out(tmr_out), .tmr_in(tmr_in), .lcd_seg(lcd_seg),
    .lcd_com(lcd_com), .sd_neg_pin(sd_neg_pin), .dac_out_en(dac_out_en));
  pfm_periph_model far (.clk(clk), .reset_n(reset_n), .flip(flip), .tmr_out(tmr_out),
    .lcd_seg(lcd_seg), .lcd_com(lcd_com));
  // Clock
  initial begin
    forever #20 clk = ~clk;
  end
  // Masked compare; the mask hides bits whose value no rule fixes
  task automatic chk(input logic [23:0] got, input logic [23:0] e,
                     input logic [23:0] m = 24'hFFFFFF);
    n_tests++;
    if ((got & m) !== (e & m)) begin
      err_total++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, e);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // Register, then pad flop: two edges
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Hang guard, far above the roughly 150 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    foreach (ROWS[i]) begin
      wr_reg(ROWS[i].a, ROWS[i].d);
      settle();
      pad = ROWS[i].p == 2'h0 ? p1_pad : (ROWS[i].p == 2'h1 ? p2_pad : p5_pad);
      chk(pad, ROWS[i].e, ROWS[i].m);
    end
    // inverted driver pattern must follow to the pads
    @(posedge clk);
    flip <= 1'b1;
    settle();
    chk(p5_pad, 24'h28FF00);
    chk(dac_out_en, 24'h000001);
    // negative inputs go to ground when analog enable clears
    wr_reg(4'hC, 8'hFF);
    rd_chk(4'hC, 8'hFC);
    chk(sd_neg_pin, 24'h000007);
    wr_reg(4'hC, 8'h00);
    settle();
    chk(sd_neg_pin, 24'h000000);
    rd_chk(4'hF, 8'h00);
    // LCD pins refuse input; plain pins pass it after the synchroniser
    @(posedge clk);
    p5_in <= 8'hFF;
    p2_in <= 8'hA6;
    wr_reg(4'h7, 8'h00);
    settle();
    rd_chk(4'h8, 8'h00);
    rd_chk(4'h4, 8'hA6);
    // A falling pin must also get through the synchroniser
    @(posedge clk);
    p2_in <= 8'h00;
    repeat (4) @(posedge clk);
    rd_chk(4'h4, 8'h00);
    // capture inputs in peripheral mode, direction 0 only
    wr_reg(4'h3, 8'hFF);
    wr_reg(4'h2, 8'h00);
    @(posedge clk);
    p1_in <= 8'h29;
    repeat (6) @(posedge clk);
    #1;
    chk(tmr_in, 24'h000019);
    wr_reg(4'h2, 8'hFF);
    settle();
    chk(tmr_in, 24'h000000);
    // second reset in mid-run restores plain I/O
    @(posedge clk);
    reset_n <= 1'b0;
    settle();
    chk(p1_pad, 24'h000000);
    @(posedge clk);
    reset_n <= 1'b1;
    settle();
    chk(p1_pad, 24'h0000FF);
    chk(p5_pad, 24'h0000FF);
    rd_chk(4'hB, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== bench/pfm_periph_model.sv ====
// Stand-in for the timer, clock system and LCD driver beside the mux
`default_nettype none
module pfm_periph_model (
  input  wire logic                     clk,      // 25 MHz clock
  input  wire logic                     reset_n,  // Async reset
  input  wire logic                     flip,     // Invert every pattern
  output var pfm_pkg::pfm_timer_out_type tmr_out,  // Timer and clocks
  output var logic [13:0]               lcd_seg,  // Segment drive
  output var logic [3:1]                lcd_com   // Common drive
);
  timeunit 1ns;
  timeprecision 1ps;
  import pfm_pkg::*;
  // Uneven patterns, so a swapped or stuck route shows at the pads
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tmr_out <= '0;
      lcd_seg <= '0;
      lcd_com <= '0;
    end else begin
      tmr_out <= flip ? ~5'h16 : 5'h16;
      lcd_seg <= flip ? ~14'h2A5B : 14'h2A5B;
      lcd_com <= flip ? ~3'h5 : 3'h5;
    end
  end
endmodule
`default_nettype wire

// ==== hw/pfm_mux.sv ====
// Pin function multiplexer for ports 1, 2 and 5
//
// Behaviour
// - After reset every pin is plain I/O
// - Analog enable kills driver and Schmitt trigger
// - Cleared analog enable ties negative input to ground
// - DAC select kills driver and Schmitt trigger
// - Port 2 pins carry segments 13 down to 6
// - Port 5 pins 0,1,5,6,7 carry segments 1,0,2,3,4
// - Port 5 pins 2..4 carry common lines 1..3
// - Port 2 segments enabled in three groups
//
// The register offsets and the strobed register port were left to the implementer.
`include "pfm_regs.svh"
`default_nettype none
module pfm_mux (
  input  wire logic                       clk,         // 25 MHz clock
  input  wire logic                       reset_n,     // Async reset
  input  wire logic [`PFM_ADDR_W-1:0]     addr,        // Register address
  input  wire logic [`PFM_DATA_W-1:0]     wdata,       // Write data
  input  wire logic                       wr,          // Write strobe
  input  wire logic                       rd,          // Read strobe
  output logic      [`PFM_DATA_W-1:0]     rdata,       // Read data
  input  wire logic [7:0]                 p1_in,       // Port 1 pad levels
  input  wire logic [7:0]                 p2_in,       // Port 2 pad levels
  input  wire logic [7:0]                 p5_in,       // Port 5 pad levels
  output pfm_pkg::pfm_pad_type            p1_pad,      // Port 1 pad drive
  output pfm_pkg::pfm_pad_type            p2_pad,      // Port 2 pad drive
  output pfm_pkg::pfm_pad_type            p5_pad,      // Port 5 pad drive
  input  wire pfm_pkg::pfm_timer_out_type tmr_out,     // Timer and clocks
  output pfm_pkg::pfm_timer_in_type       tmr_in,      // Timer inputs
  input  wire logic [13:0]                lcd_seg,     // Segment drive
  input  wire logic [3:1]                 lcd_com,     // Common drive
  output logic      [2:0]                 sd_neg_pin,  // 1: pin, 0: ground
  output logic                            dac_out_en   // DAC routed to pin
);
  import pfm_pkg::*;

  logic [7:0] p1_out_q, p1_dir_q, p1_sel_q;
  logic [7:0] p2_out_q, p2_dir_q, p2_sel_q;
  logic [7:0] p5_out_q, p5_dir_q, p5_sel_q;
  logic [7:0] ae_q, lcd_q, dac_q;
  logic [7:0] s1_q [3];
  logic [7:0] s2_q [3];
  logic [7:0] s3_q [3];
  logic [7:0] lvl_q [3];
  logic [7:0] pins [3];
  logic [7:0] rd_d;
  logic [7:0] p1_ana, p1_mod, p2_lcd_en, p2_lcd_v, p5_lcd_v;
  pfm_pad_type p1_d, p2_d, p5_d;
  pfm_timer_in_type tmr_in_d;

  assign pins[0] = p1_in;
  assign pins[1] = p2_in;
  assign pins[2] = p5_in;

  // Register writes; all selects clear so every pin starts as I/O
  // reset to plain I/O
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      p1_out_q <= `PFM_RST_BYTE;
      p1_dir_q <= `PFM_RST_BYTE;
      p1_sel_q <= `PFM_RST_BYTE;
      p2_out_q <= `PFM_RST_BYTE;
      p2_dir_q <= `PFM_RST_BYTE;
      p2_sel_q <= `PFM_RST_BYTE;
      p5_out_q <= `PFM_RST_BYTE;
      p5_dir_q <= `PFM_RST_BYTE;
      p5_sel_q <= `PFM_RST_BYTE;
      ae_q     <= `PFM_RST_BYTE;
      lcd_q    <= `PFM_RST_BYTE;
      dac_q    <= `PFM_RST_BYTE;
    end else if (wr) begin
      case (addr)
        `PFM_OFF_P1_OUT: p1_out_q <= wdata;
        `PFM_OFF_P1_DIR: p1_dir_q <= wdata;
        `PFM_OFF_P1_SEL: p1_sel_q <= wdata;
        `PFM_OFF_P2_OUT: p2_out_q <= wdata;
        `PFM_OFF_P2_DIR: p2_dir_q <= wdata;
        `PFM_OFF_P2_SEL: p2_sel_q <= wdata;
        `PFM_OFF_P5_OUT: p5_out_q <= wdata;
        `PFM_OFF_P5_DIR: p5_dir_q <= wdata;
        `PFM_OFF_P5_SEL: p5_sel_q <= wdata;
        // Only pins 2..7 of port 1 have converter inputs
        `PFM_OFF_AE:     ae_q     <= wdata & `PFM_AE_MASK;
        `PFM_OFF_LCD:    lcd_q    <= {5'h00, wdata[2:0]};
        `PFM_OFF_DAC:    dac_q    <= {7'h00, wdata[`PFM_DAC_BIT]};
        default:         ;
      endcase
    end
  end

  // Pad inputs are asynchronous: three stages, accept when the last two agree
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_sync
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          s1_q[p]  <= 8'h00;
          s2_q[p]  <= 8'h00;
          s3_q[p]  <= 8'h00;
          lvl_q[p] <= 8'h00;
        end else begin
          s1_q[p] <= pins[p];
          s2_q[p] <= s1_q[p];
          s3_q[p] <= s2_q[p];
          // Take stage 3 only where it agrees with stage 2, else hold, so a fall is seen too
          lvl_q[p] <= (s3_q[p] & ~(s2_q[p] ^ s3_q[p]))
                    | (lvl_q[p] & (s2_q[p] ^ s3_q[p]));
        end
      end
    end
  endgenerate

  // Per-pin routing tables
  // analog pins lose driver and Schmitt trigger
  assign p1_ana = ae_q | ({7'h00, dac_q[`PFM_DAC_BIT]} << `PFM_DAC_PIN);
  // output function per port 1 pin, ground where none exists
  assign p1_mod = {1'b0, 1'b0, tmr_out.aclk, 1'b0,
                   tmr_out.ta2, tmr_out.ta1, tmr_out.mclk, tmr_out.ta0};
  // three segment groups on port 2
  assign p2_lcd_en = {{2{lcd_q[`PFM_LCD_LOW]}}, {4{lcd_q[`PFM_LCD_MID]}},
                      {2{lcd_q[`PFM_LCD_HIGH]}}};
  assign p2_lcd_v = {lcd_seg[6], lcd_seg[7], lcd_seg[8], lcd_seg[9],
                     lcd_seg[10], lcd_seg[11], lcd_seg[12], lcd_seg[13]};
  // segments 1,0,2,3,4 and common lines 1..3
  assign p5_lcd_v = {lcd_seg[4], lcd_seg[3], lcd_seg[2], lcd_com[3],
                     lcd_com[2], lcd_com[1], lcd_seg[0], lcd_seg[1]};

  // Pad drive per bit; analog and LCD take priority over digital use
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      always_comb begin
        // peripheral output when direction is 1
        if (p1_ana[i]) begin
          p1_d.out[i] = 1'b0;
          p1_d.oe[i]  = 1'b0;
          p1_d.ie[i]  = 1'b0;
        end else begin
          p1_d.out[i] = p1_sel_q[i] ? p1_mod[i] : p1_out_q[i];
          p1_d.oe[i]  = p1_dir_q[i];
          p1_d.ie[i]  = 1'b1;
        end
        // Selected without LCD: direction 1 drives ground
        if (p2_lcd_en[i]) begin
          p2_d.out[i] = p2_lcd_v[i];
          p2_d.oe[i]  = 1'b1;
          p2_d.ie[i]  = 1'b0;
        end else begin
          p2_d.out[i] = p2_sel_q[i] ? 1'b0 : p2_out_q[i];
          p2_d.oe[i]  = p2_dir_q[i];
          p2_d.ie[i]  = 1'b1;
        end
        // select bit hands the pin to the LCD driver
        if (p5_sel_q[i]) begin
          p5_d.out[i] = p5_lcd_v[i];
          p5_d.oe[i]  = 1'b1;
          p5_d.ie[i]  = 1'b0;
        end else begin
          p5_d.out[i] = p5_out_q[i];
          p5_d.oe[i]  = p5_dir_q[i];
          p5_d.ie[i]  = 1'b1;
        end
      end
    end
  endgenerate

  // direction 0 routes the pin to the timer input
  always_comb begin
    tmr_in_d.cci0a = lvl_q[0][0] & p1_sel_q[0] & ~p1_dir_q[0];
    tmr_in_d.cci0b = lvl_q[0][1] & p1_sel_q[1] & ~p1_dir_q[1];
    tmr_in_d.cci1a = lvl_q[0][2] & p1_sel_q[2] & ~p1_dir_q[2] & ~p1_ana[2];
    tmr_in_d.cci2a = lvl_q[0][3] & p1_sel_q[3] & ~p1_dir_q[3] & ~p1_ana[3];
    tmr_in_d.taclk = lvl_q[0][5] & p1_sel_q[5] & ~p1_dir_q[5] & ~p1_ana[5];
  end

  // Outputs registered; costs one cycle of latency on every path
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      p1_pad     <= '0;
      p2_pad     <= '0;
      p5_pad     <= '0;
      tmr_in     <= '0;
      sd_neg_pin <= 3'h0;
      dac_out_en <= 1'b0;
    end else begin
      p1_pad     <= p1_d;
      p2_pad     <= p2_d;
      p5_pad     <= p5_d;
      tmr_in     <= tmr_in_d;
      // negative inputs on pins 2, 4, 6
      sd_neg_pin <= {ae_q[6], ae_q[4], ae_q[2]};
      dac_out_en <= dac_q[`PFM_DAC_BIT];
    end
  end

  // Read mux; a disabled Schmitt trigger reads as low
  always_comb begin
    case (addr)
      `PFM_OFF_P1_IN:  rd_d = lvl_q[0] & p1_d.ie;
      `PFM_OFF_P1_OUT: rd_d = p1_out_q;
      `PFM_OFF_P1_DIR: rd_d = p1_dir_q;
      `PFM_OFF_P1_SEL: rd_d = p1_sel_q;
      `PFM_OFF_P2_IN:  rd_d = lvl_q[1] & p2_d.ie;
      `PFM_OFF_P2_OUT: rd_d = p2_out_q;
      `PFM_OFF_P2_DIR: rd_d = p2_dir_q;
      `PFM_OFF_P2_SEL: rd_d = p2_sel_q;
      `PFM_OFF_P5_IN:  rd_d = lvl_q[2] & p5_d.ie;
      `PFM_OFF_P5_OUT: rd_d = p5_out_q;
      `PFM_OFF_P5_DIR: rd_d = p5_dir_q;
      `PFM_OFF_P5_SEL: rd_d = p5_sel_q;
      `PFM_OFF_AE:     rd_d = ae_q;
      `PFM_OFF_LCD:    rd_d = lcd_q;
      `PFM_OFF_DAC:    rd_d = dac_q;
      default:         rd_d = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? rd_d : 8'h00;
    end
  end

  // Checks
  a_reset_gpio: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> (p1_sel_q == 8'h00 && ae_q == 8'h00 && lcd_q == 8'h00
      && p5_sel_q == 8'h00 && dac_q == 8'h00 && p1_pad.oe == 8'h00))
    else $error("pins not plain I/O after reset");

  a_analog_off: assert property (@(posedge clk) disable iff (!reset_n)
    ae_q != 8'h00 |=> ((p1_pad.oe | p1_pad.ie) & $past(ae_q)) == 8'h00)
    else $error("analog pin still driven or sensed");

  a_neg_ground: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 sd_neg_pin == {$past(ae_q[6]), $past(ae_q[4]), $past(ae_q[2])})
    else $error("negative input routing wrong");

  a_dac_off: assert property (@(posedge clk) disable iff (!reset_n)
    dac_q[0] |=> !p1_pad.oe[4] && !p1_pad.ie[4] && dac_out_en)
    else $error("DAC pin not released");

  a_p2_segment: assert property (@(posedge clk) disable iff (!reset_n)
    lcd_q[2] && lcd_q[0] |=> p2_pad.out[0] == $past(lcd_seg[13])
      && p2_pad.out[7] == $past(lcd_seg[6]) && p2_pad.oe[0])
    else $error("port 2 segment order wrong");

  a_p5_segment: assert property (@(posedge clk) disable iff (!reset_n)
    p5_sel_q[0] && p5_sel_q[7] |=> p5_pad.out[0] == $past(lcd_seg[1])
      && p5_pad.out[7] == $past(lcd_seg[4]))
    else $error("port 5 segment order wrong");

  a_p5_common: assert property (@(posedge clk) disable iff (!reset_n)
    !p5_sel_q[3] ##1 p5_sel_q[3] |=> p5_pad.out[3] == $past(lcd_com[2])
      && $past(p5_pad.oe[3]) == $past(p5_dir_q[3], 2))
    else $error("common line or I/O fallback wrong");

  a_group_mid: assert property (@(posedge clk) disable iff (!reset_n)
    !lcd_q[1] && !p2_sel_q[2] |=> p2_pad.oe[2] == $past(p2_dir_q[2])
      && p2_pad.ie[2])
    else $error("mid group enable leaks to pin 2");

  a_periph_dir: assert property (@(posedge clk) disable iff (!reset_n)
    p1_sel_q[0] && p1_dir_q[0] |=> p1_pad.out[0] == $past(tmr_out.ta0)
      && p1_pad.oe[0] && !tmr_in.cci0a)
    else $error("peripheral direction routing wrong");
endmodule
`default_nettype wire

// ==== hw/pfm_pkg.sv ====
// Types shared by the port function mux and its users
`default_nettype none
package pfm_pkg;
  // Drive of one 8-pin port toward the pads
  typedef struct packed {
    logic [7:0] out;  // Output level
    logic [7:0] oe;   // Output enable, high while driven
    logic [7:0] ie;   // Schmitt trigger enable
  } pfm_pad_type;

  // Timer and clock signals offered for port 1 pins
  typedef struct packed {
    logic aclk;
    logic ta2;
    logic ta1;
    logic mclk;
    logic ta0;
  } pfm_timer_out_type;

  // Capture and clock inputs handed to the timer
  typedef struct packed {
    logic taclk;
    logic cci2a;
    logic cci1a;
    logic cci0b;
    logic cci0a;
  } pfm_timer_in_type;
endpackage
`default_nettype wire

// ==== hw/pfm_regs.svh ====
// Register offsets, field positions and reset values of the port function mux
`ifndef PFM_REGS_SVH
`define PFM_REGS_SVH

`define PFM_ADDR_W     4
`define PFM_DATA_W     8
`define PFM_OFF_P1_IN  4'h0
`define PFM_OFF_P1_OUT 4'h1
`define PFM_OFF_P1_DIR 4'h2
`define PFM_OFF_P1_SEL 4'h3
`define PFM_OFF_P2_IN  4'h4
`define PFM_OFF_P2_OUT 4'h5
`define PFM_OFF_P2_DIR 4'h6
`define PFM_OFF_P2_SEL 4'h7
`define PFM_OFF_P5_IN  4'h8
`define PFM_OFF_P5_OUT 4'h9
`define PFM_OFF_P5_DIR 4'hA
`define PFM_OFF_P5_SEL 4'hB
`define PFM_OFF_AE     4'hC
`define PFM_OFF_LCD    4'hD
`define PFM_OFF_DAC    4'hE
`define PFM_LCD_LOW    0
`define PFM_LCD_MID    1
`define PFM_LCD_HIGH   2
`define PFM_DAC_BIT    0
`define PFM_DAC_PIN    4
`define PFM_AE_MASK    8'hFC
`define PFM_RST_BYTE   8'h00

`endif
